// *** bcrx_pkg.sv ***
`default_nettype none
package bcrx_pkg;

	// cyclic image geometry
	localparam int             IMG_IN_BYTES  = 500;
	localparam int             IMG_OUT_BYTES = 4;
	localparam logic [8:0]     IMG_IN_LAST   = 9'h1f3;
	localparam logic [8:0]     DATA_MAX      = 9'h1ec;
	localparam int             DATA_DEPTH    = 492;
	localparam logic [8:0]     IMG_STAT_LO   = 9'h000;
	localparam logic [8:0]     IMG_STAT_HI   = 9'h001;
	localparam logic [8:0]     IMG_CNT_LO    = 9'h002;
	localparam logic [8:0]     IMG_CNT_HI    = 9'h003;
	localparam logic [8:0]     IMG_LEN_LO    = 9'h004;
	localparam logic [8:0]     IMG_LEN_HI    = 9'h005;
	localparam logic [8:0]     IMG_DATA      = 9'h008;
	localparam logic [1:0]     OUT_CTL_LO    = 2'h0;
	localparam logic [1:0]     OUT_CTL_HI    = 2'h1;
	localparam int             STAT_OVF_BIT  = 0;
	localparam int             CTL_XFER_BIT  = 0;
	localparam logic [15:0]    CTL_WORD_RST  = 16'h0000;
	localparam logic [15:0]    UPD_CNT_RST   = 16'h0000;

	// register map on the bus
	localparam logic [7:0]     REG_CTRL      = 8'h00;
	localparam logic [7:0]     REG_STATE     = 8'h04;
	localparam logic [7:0]     REG_IRQ_STAT  = 8'h08;
	localparam logic [7:0]     REG_IRQ_MASK  = 8'h0c;
	localparam logic [7:0]     REG_CTL_WORD  = 8'h10;
	localparam int             CTRL_CAP_BIT  = 0;
	localparam logic           CTRL_CAP_RST  = 1'b0;
	localparam int             ST_CNT_LSB    = 0;
	localparam int             ST_LEN_LSB    = 16;
	localparam int             ST_OVF_BIT    = 25;
	localparam int             ST_XFER_BIT   = 26;
	localparam int             ST_FILL_BIT   = 27;
	localparam int             IRQ_W         = 3;
	localparam int             IRQ_PUB_BIT   = 0;
	localparam int             IRQ_TRUNC_BIT = 1;
	localparam int             IRQ_DROP_BIT  = 2;
	localparam logic [2:0]     IRQ_RST       = 3'h0;
	localparam logic [31:0]    RDATA_RST     = 32'h0000_0000;

	typedef struct packed {
		logic       valid;
		logic       last;
		logic [7:0] data;
	} bcrx_byte_s;

	typedef struct packed {
		logic       en;
		logic [1:0] addr;
		logic [7:0] data;
	} bcrx_ctl_wr_s;

	typedef enum logic {BCRX_IDLE, BCRX_FILL} bcrx_fill_e;

endpackage
`default_nettype wire

// *** bcrx_record_store.sv ***
`default_nettype none
module bcrx_record_store (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic                  ce,
	input  wire logic                  capture_on,
	input  wire logic                  commit_ok,
	input  wire bcrx_pkg::bcrx_byte_s  scan_in,
	input  wire logic [8:0]            rd_idx,
	output logic      [7:0]            rd_byte,
	output logic      [8:0]            pub_len,
	output logic                       pub_ovf,
	output logic                       commit,
	output logic                       dropped,
	output logic                       truncated,
	output logic                       filling
);
	// two banks: one shown in the image, one being filled
	logic [7:0]            mem [0:1][0:bcrx_pkg::DATA_DEPTH-1];
	bcrx_pkg::bcrx_fill_e  st;
	logic                  wr_bank;
	logic [8:0]            wr_cnt;
	logic                  wr_ovf;
	logic                  accept;
	logic [8:0]            cnt_cur;
	logic                  room;
	logic [8:0]            next_cnt;
	logic                  next_ovf;

	assign accept   = scan_in.valid && (st == bcrx_pkg::BCRX_FILL || capture_on);
	assign cnt_cur  = (st == bcrx_pkg::BCRX_IDLE) ? 9'h000 : wr_cnt;
	assign room     = cnt_cur < bcrx_pkg::DATA_MAX;
	assign next_cnt = room ? cnt_cur + 9'h001 : cnt_cur;
	assign next_ovf = (st == bcrx_pkg::BCRX_FILL && wr_ovf) || !room;
	assign filling  = st == bcrx_pkg::BCRX_FILL;

	always_ff @(posedge clk) begin
		if (ce && accept && room) begin
			mem[wr_bank][cnt_cur] <= scan_in.data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st     <= bcrx_pkg::BCRX_IDLE;
			wr_cnt <= 9'h000;
			wr_ovf <= 1'b0;
		end else if (ce && accept) begin
			st     <= scan_in.last ? bcrx_pkg::BCRX_IDLE : bcrx_pkg::BCRX_FILL;
			wr_cnt <= next_cnt;
			wr_ovf <= next_ovf;
		end
	end

	// a finished record is shown only while transfer is enabled
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_bank   <= 1'b0;
			pub_len   <= 9'h000;
			pub_ovf   <= 1'b0;
			commit    <= 1'b0;
			dropped   <= 1'b0;
			truncated <= 1'b0;
		end else if (ce) begin
			commit    <= accept && scan_in.last && commit_ok;
			dropped   <= accept && scan_in.last && !commit_ok;
			truncated <= accept && scan_in.last && commit_ok && next_ovf;
			if (accept && scan_in.last && commit_ok) begin
				wr_bank <= !wr_bank;
				pub_len <= next_cnt;
				pub_ovf <= next_ovf;
			end
		end
	end

	// bytes past the length read as zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_byte <= 8'h00;
		end else if (ce) begin
			rd_byte <= (rd_idx < pub_len) ? mem[!wr_bank][rd_idx] : 8'h00;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	property p_len_max;
		pub_len <= bcrx_pkg::DATA_MAX;
	endproperty
	a_len_max: assert property (p_len_max) else $error("length above 492");

	property p_ovf_full;
		pub_ovf |-> pub_len == bcrx_pkg::DATA_MAX;
	endproperty
	a_ovf_full: assert property (p_ovf_full) else $error("overflow without full record");

	sequence s_over_end;
		ce && accept && scan_in.last && commit_ok && !room;
	endsequence
	property p_trunc;
		s_over_end |=> pub_ovf && truncated && pub_len == bcrx_pkg::DATA_MAX;
	endproperty
	a_trunc: assert property (p_trunc) else $error("long record not truncated");

	property p_no_commit_disabled;
		ce && accept && scan_in.last && !commit_ok |=> !commit && dropped && $stable(wr_bank);
	endproperty
	a_no_commit_disabled: assert property (p_no_commit_disabled) else $error("record shown while disabled");

endmodule // bcrx_record_store
`default_nettype wire

// *** bcrx_top.sv ***
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`default_nettype none
module bcrx_top (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   ce,
	input  wire logic                   hsel,
	input  wire logic [31:0]            haddr,
	input  wire logic [1:0]             htrans,
	input  wire logic                   hwrite,
	input  wire logic [2:0]             hsize,
	input  wire logic [31:0]            hwdata,
	input  wire logic                   hready,
	output logic                        hreadyout,
	output logic                        hresp,
	output logic      [31:0]            hrdata,
	input  wire bcrx_pkg::bcrx_byte_s   scan_in,
	input  wire bcrx_pkg::bcrx_ctl_wr_s ctl_wr,
	input  wire logic [8:0]             img_rd_addr,
	output logic      [7:0]             img_rd_data,
	output logic                        xfer_enable,
	output logic                        irq
);
	logic                          ctrl_capture;
	logic [15:0]                   ctl_word;
	logic [15:0]                   update_count;
	logic [15:0]                   next_count;
	logic [bcrx_pkg::IRQ_W-1:0]    irq_status;
	logic [bcrx_pkg::IRQ_W-1:0]    irq_mask;
	logic [bcrx_pkg::IRQ_W-1:0]    irq_events;
	logic [bcrx_pkg::IRQ_W-1:0]    irq_w1c;
	logic                          dph;
	logic                          dph_write;
	logic [7:0]                    dph_addr;
	logic [31:0]                   next_rdata;
	logic [8:0]                    rd_addr_q;
	logic [8:0]                    rd_idx;
	logic [7:0]                    st_byte;
	logic [8:0]                    pub_len;
	logic                          pub_ovf;
	logic                          commit;
	logic                          dropped;
	logic                          truncated;
	logic                          filling;
	logic [15:0]                   status_word;
	logic [15:0]                   len_word;
	logic                          bus_wr;

	assign xfer_enable = ctl_word[bcrx_pkg::CTL_XFER_BIT];
	assign rd_idx      = img_rd_addr - bcrx_pkg::IMG_DATA;
	assign status_word = {15'h0000, pub_ovf};
	assign len_word    = {7'h00, pub_len};
	assign irq_events  = {dropped, truncated, commit};
	assign bus_wr      = dph && dph_write;
	assign irq_w1c     = (bus_wr && dph_addr == bcrx_pkg::REG_IRQ_STAT) ?
		hwdata[bcrx_pkg::IRQ_W-1:0] : 3'h0;
	assign next_count  = (update_count == 16'hffff) ? 16'h0001 :
		update_count + 16'h0001;

	bcrx_record_store u_store (
		.clk        (hclk),
		.rst_n      (hresetn),
		.ce         (ce),
		.capture_on (ctrl_capture),
		.commit_ok  (xfer_enable),
		.scan_in    (scan_in),
		.rd_idx     (rd_idx),
		.rd_byte    (st_byte),
		.pub_len    (pub_len),
		.pub_ovf    (pub_ovf),
		.commit     (commit),
		.dropped    (dropped),
		.truncated  (truncated),
		.filling    (filling)
	);

	// control word written by the controller through the output image
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctl_word <= bcrx_pkg::CTL_WORD_RST;
		end else if (ce && ctl_wr.en) begin
			if (ctl_wr.addr == bcrx_pkg::OUT_CTL_LO) begin
				ctl_word[7:0] <= ctl_wr.data;
			end else if (ctl_wr.addr == bcrx_pkg::OUT_CTL_HI) begin
				ctl_word[15:8] <= ctl_wr.data;
			end
		end
	end

	// counter moves one cycle after the new data and length are shown
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			update_count <= bcrx_pkg::UPD_CNT_RST;
		end else if (ce && commit) begin
			update_count <= next_count;
		end
	end

	// input image read: two-cycle pipeline
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_addr_q   <= 9'h000;
			img_rd_data <= 8'h00;
		end else if (ce) begin
			rd_addr_q <= img_rd_addr;
			if (rd_addr_q >= bcrx_pkg::IMG_DATA && rd_addr_q <= bcrx_pkg::IMG_IN_LAST) begin
				img_rd_data <= st_byte;
			end else begin
				case (rd_addr_q)
					bcrx_pkg::IMG_STAT_LO: img_rd_data <= status_word[7:0];
					bcrx_pkg::IMG_STAT_HI: img_rd_data <= status_word[15:8];
					bcrx_pkg::IMG_CNT_LO:  img_rd_data <= update_count[7:0];
					bcrx_pkg::IMG_CNT_HI:  img_rd_data <= update_count[15:8];
					bcrx_pkg::IMG_LEN_LO:  img_rd_data <= len_word[7:0];
					bcrx_pkg::IMG_LEN_HI:  img_rd_data <= len_word[15:8];
					default:               img_rd_data <= 8'h00;
				endcase
			end
		end
	end

	// bus slave: one wait state on every transfer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dph       <= 1'b0;
			dph_write <= 1'b0;
			dph_addr  <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= bcrx_pkg::RDATA_RST;
		end else if (ce) begin
			hresp <= 1'b0;
			if (dph) begin
				dph       <= 1'b0;
				hreadyout <= 1'b1;
				if (!dph_write) begin
					hrdata <= next_rdata;
				end
			end else if (hsel && htrans[1] && hready) begin
				dph       <= 1'b1;
				dph_write <= hwrite;
				dph_addr  <= {haddr[7:2], 2'b00};
				hreadyout <= 1'b0;
			end
		end
	end

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (dph_addr)
			bcrx_pkg::REG_CTRL: begin
				next_rdata[bcrx_pkg::CTRL_CAP_BIT] = ctrl_capture;
			end
			bcrx_pkg::REG_STATE: begin
				next_rdata[bcrx_pkg::ST_CNT_LSB +: 16] = update_count;
				next_rdata[bcrx_pkg::ST_LEN_LSB +: 9]  = pub_len;
				next_rdata[bcrx_pkg::ST_OVF_BIT]       = pub_ovf;
				next_rdata[bcrx_pkg::ST_XFER_BIT]      = xfer_enable;
				next_rdata[bcrx_pkg::ST_FILL_BIT]      = filling;
			end
			bcrx_pkg::REG_IRQ_STAT: begin
				next_rdata[bcrx_pkg::IRQ_W-1:0] = irq_status;
			end
			bcrx_pkg::REG_IRQ_MASK: begin
				next_rdata[bcrx_pkg::IRQ_W-1:0] = irq_mask;
			end
			bcrx_pkg::REG_CTL_WORD: begin
				next_rdata[15:0] = ctl_word;
			end
			default: begin
				next_rdata = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_capture <= bcrx_pkg::CTRL_CAP_RST;
			irq_mask     <= bcrx_pkg::IRQ_RST;
		end else if (ce && bus_wr) begin
			if (dph_addr == bcrx_pkg::REG_CTRL) begin
				ctrl_capture <= hwdata[bcrx_pkg::CTRL_CAP_BIT];
			end
			if (dph_addr == bcrx_pkg::REG_IRQ_MASK) begin
				irq_mask <= hwdata[bcrx_pkg::IRQ_W-1:0];
			end
		end
	end

	// a new event wins over a clear in the same cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_status <= bcrx_pkg::IRQ_RST;
			irq        <= 1'b0;
		end else if (ce) begin
			irq_status <= (irq_status & ~irq_w1c) | irq_events;
			irq        <= |(irq_status & irq_mask);
		end
	end

	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	property p_cnt_change;
		ce && commit |=> update_count != $past(update_count) && update_count != 16'h0000;
	endproperty
	a_cnt_change: assert property (p_cnt_change) else $error("counter did not change on record");

	property p_cnt_hold;
		!(ce && commit) |=> $stable(update_count);
	endproperty
	a_cnt_hold: assert property (p_cnt_hold) else $error("counter changed without record");

	property p_ctl_lo;
		ce && ctl_wr.en && ctl_wr.addr == bcrx_pkg::OUT_CTL_LO |=>
			xfer_enable == $past(ctl_wr.data[0]);
	endproperty
	a_ctl_lo: assert property (p_ctl_lo) else $error("transfer bit not taken");

	property p_ctl_rsvd;
		ce && ctl_wr.en && ctl_wr.addr[1] |=> $stable(ctl_word);
	endproperty
	a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("reserved output bytes changed control");

	sequence s_rd_cnt;
		ce && img_rd_addr == bcrx_pkg::IMG_CNT_LO ##1 ce;
	endsequence
	property p_rd_cnt;
		s_rd_cnt |=> img_rd_data == $past(update_count[7:0]);
	endproperty
	a_rd_cnt: assert property (p_rd_cnt) else $error("image counter byte wrong");

	sequence s_rd_out;
		ce && img_rd_addr > bcrx_pkg::IMG_IN_LAST ##1 ce;
	endsequence
	property p_rd_out;
		s_rd_out |=> img_rd_data == 8'h00;
	endproperty
	a_rd_out: assert property (p_rd_out) else $error("read past 500 bytes not zero");

	sequence s_acc;
		ce && hsel && htrans[1] && hready && !dph;
	endsequence
	property p_bus_wait;
		s_acc |=> (!hreadyout and (ce |=> hreadyout));
	endproperty
	a_bus_wait: assert property (p_bus_wait) else $error("bus wait state wrong");

	property p_irq;
		ce |=> irq == |($past(irq_status & irq_mask));
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt level wrong");

endmodule // bcrx_top
`default_nettype wire

// *** bcrx_ctl_model.sv ***
`default_nettype none
module bcrx_ctl_model (
	input  wire logic                   hclk,
	input  wire logic                   hresetn,
	input  wire logic                   transfer_request_flag,
	input  wire logic [7:0]             img_rd_data,
	output var  bcrx_pkg::bcrx_ctl_wr_s ctl_wr,
	output logic      [8:0]             img_rd_addr,
	output logic                        new_record_strobe,
	output logic      [15:0]            latched_update_count,
	output logic      [8:0]             latched_record_length,
	output logic                        latched_truncation_flag,
	output logic      [15:0][7:0]       latched_record_bytes
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [15:0] previous_update_count;
	logic        xfer_was_on;
	logic [15:0] cnt;
	logic [15:0] len;
	logic [7:0]  stat;

	// image reads answer after two edges; sample once they have landed
	task automatic rd(input logic [8:0] a, output logic [7:0] d);
		@(posedge hclk);
		img_rd_addr <= a;
		repeat (2) @(posedge hclk);
		#1 d = img_rd_data;
	endtask

	task automatic wr_ctl(input logic [1:0] a, input logic [7:0] d);
		@(posedge hclk);
		ctl_wr <= '{en: 1'h1, addr: a, data: d};
		@(posedge hclk);
		ctl_wr <= '0;
	endtask

	initial begin
		ctl_wr = '0;
		img_rd_addr = 9'h000;
		new_record_strobe = 1'h0;
		latched_update_count = 16'h0000;
		latched_record_length = 9'h000;
		latched_truncation_flag = 1'h0;
		latched_record_bytes = '0;
		previous_update_count = 16'h0000;
		xfer_was_on = 1'h0;
		wait (hresetn === 1'h1);
		// spare output bytes and a read past the input image
		wr_ctl(2'h2, 8'hff);
		wr_ctl(2'h3, 8'hff);
		rd(bcrx_pkg::IMG_IN_LAST + 9'h001, stat);
		// one evaluation per scan, starting with the second scan after transfer is requested
		forever begin
			wr_ctl(bcrx_pkg::OUT_CTL_LO, {7'h00, transfer_request_flag});
			wr_ctl(bcrx_pkg::OUT_CTL_HI, 8'h00);
			rd(bcrx_pkg::IMG_CNT_LO, cnt[7:0]);
			rd(bcrx_pkg::IMG_CNT_HI, cnt[15:8]);
			if (transfer_request_flag && !xfer_was_on) begin
				previous_update_count = cnt;
			end else if (transfer_request_flag &&
				cnt != previous_update_count) begin
				rd(bcrx_pkg::IMG_LEN_LO, len[7:0]);
				rd(bcrx_pkg::IMG_LEN_HI, len[15:8]);
				rd(bcrx_pkg::IMG_STAT_LO, stat);
				latched_record_bytes = '0;
				// only the first length bytes are meaningful
				for (int i = 0; i < 16 && i < int'(len); i++) begin
					rd(bcrx_pkg::IMG_DATA + 9'(i), latched_record_bytes[i]);
				end
				latched_update_count = cnt;
				latched_record_length = len[8:0];
				latched_truncation_flag = stat[bcrx_pkg::STAT_OVF_BIT];
				previous_update_count = cnt;
				@(posedge hclk);
				new_record_strobe <= 1'h1;
				@(posedge hclk);
				new_record_strobe <= 1'h0;
			end
			// disabled: neither strobe nor latch update
			xfer_was_on = transfer_request_flag;
		end
	end
endmodule // bcrx_ctl_model
`default_nettype wire

// *** bcrx_top_tb.sv ***
`default_nettype none
module bcrx_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic                   hclk;
	logic                   hresetn;
	logic                   hsel;
	logic                   hwrite;
	logic [1:0]             htrans;
	logic [2:0]             hsize;
	logic [31:0]            haddr;
	logic [31:0]            hwdata;
	logic [31:0]            hrdata;
	logic                   hreadyout;
	logic                   hresp;
	logic                   xfer_enable;
	logic                   irq;
	logic                   req;
	logic                   stb;
	logic [7:0]             img_rd_data;
	logic [8:0]             img_rd_addr;
	logic [15:0]            l_cnt;
	logic [8:0]             l_len;
	logic                   l_ovf;
	logic [15:0][7:0]       l_bytes;
	logic [31:0]            rd;
	bcrx_pkg::bcrx_byte_s   scan_in;
	bcrx_pkg::bcrx_ctl_wr_s ctl_wr;
	int                     fails = 0;
	int                     n_checks = 0;
	int                     nstb = 0;
	int                     n;
	int                     s;

	bcrx_top u_bcrx_top (.hclk(hclk), .hresetn(hresetn), .ce(1'h1),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.scan_in(scan_in), .ctl_wr(ctl_wr), .img_rd_addr(img_rd_addr),
		.img_rd_data(img_rd_data), .xfer_enable(xfer_enable), .irq(irq));

	bcrx_ctl_model u_bcrx_ctl_model (.hclk(hclk), .hresetn(hresetn),
		.transfer_request_flag(req), .img_rd_data(img_rd_data),
		.ctl_wr(ctl_wr), .img_rd_addr(img_rd_addr),
		.new_record_strobe(stb), .latched_update_count(l_cnt),
		.latched_record_length(l_len), .latched_truncation_flag(l_ovf),
		.latched_record_bytes(l_bytes));

	initial begin
		hclk = 1'h0;
		forever #5 hclk = ~hclk;
	end

	always @(posedge hclk) begin
		if (stb === 1'h1)
			nstb <= nstb + 1;
	end

	task automatic stop_test;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic guard;
		if (n >= 4000) begin
			fails++;
			$display("[ERR] %0t timeout got %h exp %h", $time, n, 0);
			stop_test;
		end
	endtask

	// wait for hready high at a rising edge, taking read data with it
	task automatic rdy;
		n = 0;
		@(negedge hclk);
		while (hreadyout !== 1'h1 && n < 4000) begin
			@(negedge hclk);
			n++;
		end
		guard;
		rd = hrdata;
		@(posedge hclk);
	endtask

	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= 2'h2;
		hwrite <= w;
		hsize <= 3'h2;
		haddr <= {24'h00_0000, a};
		rdy;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'h0, a, 32'h0000_0000);
		chk(rd, exp);
		chk(32'(hresp), 32'h0000_0000);
	endtask

	task automatic send(input int cnt, input logic [7:0] base);
		for (int k = 0; k < cnt; k++) begin
			@(posedge hclk);
			scan_in <= '{valid: 1'h1, last: (k == cnt - 1), data: base + 8'(k)};
		end
		@(posedge hclk);
		scan_in <= '0;
	endtask

	task automatic wcnt(input logic [15:0] c);
		n = 0;
		while (l_cnt !== c && n < 4000) begin
			@(posedge hclk);
			n++;
		end
		guard;
		// strobe follows the latch; let its count settle
		repeat (2) @(posedge hclk);
	endtask

	task automatic wxe(input logic v);
		n = 0;
		while (xfer_enable !== v && n < 4000) begin
			@(posedge hclk);
			n++;
		end
		guard;
		@(posedge hclk);
	endtask

	initial begin
		hresetn = 1'h0;
		hsel = 1'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hsize = 3'h2;
		haddr = 32'h0000_0000;
		hwdata = 32'h0000_0000;
		scan_in = '0;
		req = 1'h1;
		repeat (5) @(posedge hclk);
		hresetn <= 1'h1;
		@(posedge hclk);
		rchk(bcrx_pkg::REG_CTRL, 32'h0000_0000);
		rchk(bcrx_pkg::REG_IRQ_STAT, 32'h0000_0000);
		rchk(bcrx_pkg::REG_IRQ_MASK, 32'h0000_0000);
		rchk(8'h14, 32'h0000_0000);
		wxe(1'h1);
		rchk(bcrx_pkg::REG_CTL_WORD, 32'h0000_0001);
		ahb(1'h1, bcrx_pkg::REG_IRQ_MASK, 32'h0000_0007);
		ahb(1'h1, bcrx_pkg::REG_CTRL, 32'h0000_0001);
		// plain three byte record
		send(3, 8'ha1);
		wcnt(16'h0001);
		chk(32'(l_len), 32'h0000_0003);
		chk(32'(l_bytes[0]), 32'h0000_00a1);
		chk(32'(l_bytes[2]), 32'h0000_00a3);
		chk(32'(l_ovf), 32'h0000_0000);
		chk(32'(nstb), 32'h0000_0001);
		rchk(bcrx_pkg::REG_STATE, 32'h0403_0001);
		rchk(bcrx_pkg::REG_IRQ_STAT, 32'h0000_0001);
		chk(32'(irq), 32'h0000_0001);
		ahb(1'h1, bcrx_pkg::REG_IRQ_STAT, 32'h0000_0001);
		rchk(bcrx_pkg::REG_IRQ_STAT, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		// records back to back: only the newest counter matters
		send(2, 8'hb0);
		send(1, 8'hc0);
		wcnt(16'h0003);
		chk(32'(l_len), 32'h0000_0001);
		chk(32'(l_bytes[0]), 32'h0000_00c0);
		// two bytes beyond the data area
		send(494, 8'h00);
		wcnt(16'h0004);
		chk(32'(l_len), 32'h0000_01ec);
		chk(32'(l_ovf), 32'h0000_0001);
		chk(32'(l_bytes[15]), 32'h0000_000f);
		rchk(bcrx_pkg::REG_IRQ_STAT, 32'h0000_0003);
		ahb(1'h1, bcrx_pkg::REG_IRQ_MASK, 32'h0000_0000);
		rchk(bcrx_pkg::REG_IRQ_MASK, 32'h0000_0000);
		chk(32'(irq), 32'h0000_0000);
		ahb(1'h1, bcrx_pkg::REG_IRQ_MASK, 32'h0000_0002);
		rchk(bcrx_pkg::REG_IRQ_MASK, 32'h0000_0002);
		chk(32'(irq), 32'h0000_0001);
		ahb(1'h1, bcrx_pkg::REG_IRQ_STAT, 32'h0000_0003);
		ahb(1'h1, bcrx_pkg::REG_IRQ_MASK, 32'h0000_0007);
		rchk(bcrx_pkg::REG_IRQ_STAT, 32'h0000_0000);
		// transfer stopped: record dropped, counter still
		s = nstb;
		req <= 1'h0;
		wxe(1'h0);
		send(2, 8'hd0);
		repeat (20) @(posedge hclk);
		rchk(bcrx_pkg::REG_STATE, 32'h03ec_0004);
		rchk(bcrx_pkg::REG_IRQ_STAT, 32'h0000_0004);
		chk(32'(irq), 32'h0000_0001);
		chk(32'(nstb), 32'(s));
		// re-enable: stale counter must not look new
		req <= 1'h1;
		wxe(1'h1);
		repeat (400) @(posedge hclk);
		chk(32'(nstb), 32'(s));
		send(1, 8'he0);
		wcnt(16'h0005);
		chk(32'(l_bytes[0]), 32'h0000_00e0);
		chk(32'(nstb), 32'(s + 1));
		stop_test;
	end
endmodule // bcrx_top_tb
`default_nettype wire
